// >>> pkg/pdf_defines.vh
// Register offsets, field positions, reset values and timing for the PWM back end.
`ifndef PDF_DEFINES_VH
`define PDF_DEFINES_VH

`define PDF_OFS_CTL        12'h000
`define PDF_OFS_SYNC       12'h004
`define PDF_OFS_ENABLE     12'h008
`define PDF_OFS_INVERT     12'h00c
`define PDF_OFS_FAULT      12'h010
`define PDF_OFS_INTEN      12'h014
`define PDF_OFS_RIS        12'h018
`define PDF_OFS_ISC        12'h01c
`define PDF_OFS_STATUS     12'h020
`define PDF_OFS_GCTL       12'h040
`define PDF_OFS_GINTEN     12'h044
`define PDF_OFS_GRIS       12'h048
`define PDF_OFS_GISC       12'h04c
`define PDF_OFS_LOAD       12'h050
`define PDF_OFS_COUNT      12'h054
`define PDF_OFS_CMPA       12'h058
`define PDF_OFS_CMPB       12'h05c
`define PDF_OFS_GENA       12'h060
`define PDF_OFS_GENB       12'h064
`define PDF_OFS_DBCTL      12'h068
`define PDF_OFS_DBRISE     12'h06c
`define PDF_OFS_DBFALL     12'h070

// Generator control fields.
`define PDF_GCTL_RUN       0
`define PDF_GCTL_UPDOWN    1
`define PDF_GCTL_SYNCUPD   2
`define PDF_GCTL_DBGRUN    3
// Interrupt fields.
`define PDF_INT_FAULT      16
`define PDF_INT_GEN0       0
// Generator event bit order: zero, load, a-up, a-down, b-up, b-down.
`define PDF_EV_ZERO        0
`define PDF_EV_LOAD        1
`define PDF_EV_AUP         2
`define PDF_EV_ADN         3
`define PDF_EV_BUP         4
`define PDF_EV_BDN         5

`define PDF_RESET_VAL      32'h0000_0000
`define PDF_CLK_HZ         40000000

`endif

// >>> hw/pdf_deadband.v
// Dead-band delay stage for one generator.
`timescale 1ns/1ps
module pdf_deadband (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        enable_i,
    input  wire [11:0] rise_delay_i,
    input  wire [11:0] fall_delay_i,
    input  wire        raw_wave_first_i,
    input  wire        raw_wave_second_i,
    output reg         db_first_o,
    output reg         db_second_o
);
    reg        prev_reg;
    reg [11:0] rise_cnt_reg;
    reg [11:0] fall_cnt_reg;
    wire       in_rise = raw_wave_first_i & ~prev_reg;
    wire       in_fall = ~raw_wave_first_i & prev_reg;

    // Both outputs are registered so the pins see no combinational glitches.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_reg     <= 1'b0;
            rise_cnt_reg <= 12'h000;
            fall_cnt_reg <= 12'h000;
            db_first_o   <= 1'b0;
            db_second_o  <= 1'b0;
        end else begin
            prev_reg <= raw_wave_first_i;
            if (!enable_i) begin
                db_first_o   <= raw_wave_first_i;
                db_second_o  <= raw_wave_second_i;
                rise_cnt_reg <= 12'h000;
                fall_cnt_reg <= 12'h000;
            end else begin
                // The falling input edge drops the first output at once.
                if (!raw_wave_first_i) begin
                    db_first_o   <= 1'b0;
                    rise_cnt_reg <= 12'h000;
                end else if (in_rise) begin
                    rise_cnt_reg <= rise_delay_i;
                    db_first_o   <= (rise_delay_i == 12'h000);
                end else if (rise_cnt_reg > 12'h001) begin
                    rise_cnt_reg <= rise_cnt_reg - 12'h001;
                end else begin
                    rise_cnt_reg <= 12'h000;
                    db_first_o   <= 1'b1;
                end
                // The second output is the complement with delayed rise.
                if (raw_wave_first_i) begin
                    db_second_o  <= 1'b0;
                    fall_cnt_reg <= 12'h000;
                end else if (in_fall) begin
                    fall_cnt_reg <= fall_delay_i;
                    db_second_o  <= (fall_delay_i == 12'h000);
                end else if (fall_cnt_reg > 12'h001) begin
                    fall_cnt_reg <= fall_cnt_reg - 12'h001;
                end else begin
                    fall_cnt_reg <= 12'h000;
                    db_second_o  <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> hw/pdf_top.v
// PWM back end: register bank, counter sync, dead-band, fault and outputs.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pdf_defines.vh"
module pdf_top (
    input  wire        clk_i,
    input  wire        reset_n_i,
    // AXI4-Lite slave.
    input  wire [11:0] s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [11:0] s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // Generator front end.
    input  wire        raw_wave_first_i,
    input  wire        raw_wave_second_i,
    input  wire [5:0]  counter_event_i,
    // Conditions and pins.
    input  wire        fault_pin_i,
    input  wire        debug_stall_i,
    output wire        out_channel_zero_o,
    output wire        out_channel_one_o,
    output reg         irq_o
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg        global_update_reg;
    reg        counter_sync_request_reg;
    reg [1:0]  output_pin_enable_reg;
    reg [1:0]  output_polarity_invert_reg;
    reg [1:0]  output_fault_force_reg;
    reg        irq_en_gen_reg;
    reg        irq_en_fault_reg;
    reg        fault_latch_reg;
    reg [3:0]  gen_control_reg;
    reg [5:0]  gen_irq_enable_reg;
    reg [5:0]  gen_raw_reg;
    reg [15:0] load_pend_reg;
    reg [15:0] load_act_reg;
    reg [15:0] cmpa_pend_reg;
    reg [15:0] cmpa_act_reg;
    reg [15:0] cmpb_pend_reg;
    reg [15:0] cmpb_act_reg;
    reg [15:0] count_reg;
    reg        dir_up_reg;
    reg [31:0] gen_actions_first_reg;
    reg [31:0] gen_actions_second_reg;
    reg        deadband_control_reg;
    reg [11:0] deadband_rise_delay_reg;
    reg [11:0] deadband_fall_delay_reg;
    reg        dirty_reg;
    reg        fault_meta_reg;
    reg        fault_sync_reg;
    reg        stall_meta_reg;
    reg        stall_sync_reg;
    reg        aw_held_reg;
    reg        w_held_reg;
    reg [11:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Address and data are latched separately, so either may come first.
    assign s_axi_awready_o = ~aw_held_reg & ~s_axi_bvalid_o;
    assign s_axi_wready_o  = ~w_held_reg & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ~s_axi_rvalid_o;

    wire        wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
    wire [31:0] wd    = w_data_reg;
    wire        ws    = &w_strb_reg;

    function wr_hit;
        input [11:0] ofs;
        begin
            wr_hit = wr_go & ws & ({aw_addr_reg[11:2], 2'b00} == ofs);
        end
    endfunction

    wire fault_cond = fault_sync_reg | stall_sync_reg;
    wire cnt_zero   = (count_reg == 16'h0000);
    wire running    = gen_control_reg[`PDF_GCTL_RUN];
    // Stall with the stop option lets the counter run down to zero only.
    wire halt = stall_sync_reg & ~gen_control_reg[`PDF_GCTL_DBGRUN]
                & cnt_zero;
    wire tick = running & ~halt;

    wire apply = cnt_zero & tick & dirty_reg &
                 (~gen_control_reg[`PDF_GCTL_SYNCUPD] |
                  global_update_reg);

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            aw_addr_reg    <= 12'h000;
            w_data_reg     <= 32'h0000_0000;
            w_strb_reg     <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= 2'b00;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_held_reg    <= 1'b0;
                w_held_reg     <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= 2'b00;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Register writes and generator state
    // ****************************************************************
    // Partial-strobe writes are acknowledged but dropped: every field
    // here is updated as a whole word to keep pending values coherent.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            global_update_reg          <= 1'b0;
            counter_sync_request_reg   <= 1'b0;
            output_pin_enable_reg      <= 2'b00;
            output_polarity_invert_reg <= 2'b00;
            output_fault_force_reg     <= 2'b00;
            irq_en_gen_reg             <= 1'b0;
            irq_en_fault_reg           <= 1'b0;
            fault_latch_reg            <= 1'b0;
            gen_control_reg            <= 4'h0;
            gen_irq_enable_reg         <= 6'h00;
            gen_raw_reg                <= 6'h00;
            load_pend_reg              <= 16'h0000;
            load_act_reg               <= 16'h0000;
            cmpa_pend_reg              <= 16'h0000;
            cmpa_act_reg               <= 16'h0000;
            cmpb_pend_reg              <= 16'h0000;
            cmpb_act_reg               <= 16'h0000;
            count_reg                  <= 16'h0000;
            dir_up_reg                 <= 1'b0;
            gen_actions_first_reg      <= 32'h0000_0000;
            gen_actions_second_reg     <= 32'h0000_0000;
            deadband_control_reg       <= 1'b0;
            deadband_rise_delay_reg    <= 12'h000;
            deadband_fall_delay_reg    <= 12'h000;
            dirty_reg                  <= 1'b0;
        end else begin
            if (wr_hit(`PDF_OFS_CTL) && wd[0])
                global_update_reg <= 1'b1;
            else if (apply)
                global_update_reg <= 1'b0;
            if (wr_hit(`PDF_OFS_SYNC) && wd[0])
                counter_sync_request_reg <= 1'b1;
            else
                counter_sync_request_reg <= 1'b0;
            if (wr_hit(`PDF_OFS_ENABLE))
                output_pin_enable_reg <= wd[1:0];
            if (wr_hit(`PDF_OFS_INVERT))
                output_polarity_invert_reg <= wd[1:0];
            if (wr_hit(`PDF_OFS_FAULT))
                output_fault_force_reg <= wd[1:0];
            if (wr_hit(`PDF_OFS_INTEN)) begin
                irq_en_gen_reg   <= wd[`PDF_INT_GEN0];
                irq_en_fault_reg <= wd[`PDF_INT_FAULT];
            end
            // Only the pin sets the latch; a stall never does.
            if (fault_sync_reg)
                fault_latch_reg <= 1'b1;
            else if (wr_hit(`PDF_OFS_ISC) && wd[`PDF_INT_FAULT])
                fault_latch_reg <= 1'b0;
            if (wr_hit(`PDF_OFS_GCTL))
                gen_control_reg <= wd[3:0];
            if (wr_hit(`PDF_OFS_GINTEN))
                gen_irq_enable_reg <= wd[5:0];
            // Raw events are latched before any dead-band delay.
            if (wr_hit(`PDF_OFS_GISC))
                gen_raw_reg <= (gen_raw_reg & ~wd[5:0]) |
                               counter_event_i;
            else
                gen_raw_reg <= gen_raw_reg | counter_event_i;
            if (wr_hit(`PDF_OFS_LOAD)) begin
                load_pend_reg <= wd[15:0];
                dirty_reg     <= 1'b1;
            end else if (wr_hit(`PDF_OFS_CMPA)) begin
                cmpa_pend_reg <= wd[15:0];
                dirty_reg     <= 1'b1;
            end else if (wr_hit(`PDF_OFS_CMPB)) begin
                cmpb_pend_reg <= wd[15:0];
                dirty_reg     <= 1'b1;
            end else if (apply) begin
                dirty_reg <= 1'b0;
            end
            if (apply) begin
                load_act_reg <= load_pend_reg;
                cmpa_act_reg <= cmpa_pend_reg;
                cmpb_act_reg <= cmpb_pend_reg;
            end
            if (wr_hit(`PDF_OFS_GENA))
                gen_actions_first_reg <= wd;
            if (wr_hit(`PDF_OFS_GENB))
                gen_actions_second_reg <= wd;
            if (wr_hit(`PDF_OFS_DBCTL))
                deadband_control_reg <= wd[0];
            if (wr_hit(`PDF_OFS_DBRISE))
                deadband_rise_delay_reg <= wd[11:0];
            if (wr_hit(`PDF_OFS_DBFALL))
                deadband_fall_delay_reg <= wd[11:0];
            // Counter: in down mode the load value holds period minus one; up-down mode counts 0 to load and back.
            if (counter_sync_request_reg) begin
                count_reg  <= 16'h0000;
                dir_up_reg <= 1'b1;
            end else if (tick) begin
                if (!gen_control_reg[`PDF_GCTL_UPDOWN]) begin
                    dir_up_reg <= 1'b0;
                    if (cnt_zero)
                        count_reg <= apply ? load_pend_reg
                                           : load_act_reg;
                    else
                        count_reg <= count_reg - 16'h0001;
                end else if (dir_up_reg) begin
                    if (count_reg >= load_act_reg) begin
                        dir_up_reg <= 1'b0;
                        count_reg  <= count_reg - 16'h0001;
                    end else begin
                        count_reg <= count_reg + 16'h0001;
                    end
                end else begin
                    if (cnt_zero) begin
                        dir_up_reg <= 1'b1;
                        count_reg  <= 16'h0001;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Condition synchronisers and read path
    // ****************************************************************
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_meta_reg <= 1'b0;
            fault_sync_reg <= 1'b0;
            stall_meta_reg <= 1'b0;
            stall_sync_reg <= 1'b0;
        end else begin
            fault_meta_reg <= fault_pin_i;
            fault_sync_reg <= fault_meta_reg;
            stall_meta_reg <= debug_stall_i;
            stall_sync_reg <= stall_meta_reg;
        end
    end

    wire        gen_irq   = |(gen_raw_reg & gen_irq_enable_reg);
    wire [31:0] ris_word  = {15'h0000, fault_latch_reg, 15'h0000,
                             |gen_raw_reg};
    wire [31:0] isc_word  = {15'h0000, fault_latch_reg & irq_en_fault_reg,
                             15'h0000, gen_irq & irq_en_gen_reg};
    reg  [31:0] rd_next;
    reg  [1:0]  rresp_next;

    always @* begin
        rd_next    = 32'h0000_0000;
        rresp_next = 2'b00;
        case ({s_axi_araddr_i[11:2], 2'b00})
            `PDF_OFS_CTL:    rd_next = {31'h0000_0000, global_update_reg};
            `PDF_OFS_SYNC:   rd_next = {31'h0000_0000,
                                        counter_sync_request_reg};
            `PDF_OFS_ENABLE: rd_next = {30'h0000_0000,
                                        output_pin_enable_reg};
            `PDF_OFS_INVERT: rd_next = {30'h0000_0000,
                                        output_polarity_invert_reg};
            `PDF_OFS_FAULT:  rd_next = {30'h0000_0000,
                                        output_fault_force_reg};
            `PDF_OFS_INTEN:  rd_next = {15'h0000, irq_en_fault_reg,
                                        15'h0000, irq_en_gen_reg};
            `PDF_OFS_RIS:    rd_next = ris_word;
            `PDF_OFS_ISC:    rd_next = isc_word;
            `PDF_OFS_STATUS: rd_next = {31'h0000_0000,
                                        fault_sync_reg};
            `PDF_OFS_GCTL:   rd_next = {28'h000_0000, gen_control_reg};
            `PDF_OFS_GINTEN: rd_next = {26'h000_0000, gen_irq_enable_reg};
            `PDF_OFS_GRIS:   rd_next = {26'h000_0000, gen_raw_reg};
            `PDF_OFS_GISC:   rd_next = {26'h000_0000,
                                        gen_raw_reg & gen_irq_enable_reg};
            `PDF_OFS_LOAD:   rd_next = {16'h0000, load_pend_reg};
            `PDF_OFS_COUNT:  rd_next = {16'h0000, count_reg};
            `PDF_OFS_CMPA:   rd_next = {16'h0000, cmpa_pend_reg};
            `PDF_OFS_CMPB:   rd_next = {16'h0000, cmpb_pend_reg};
            `PDF_OFS_GENA:   rd_next = gen_actions_first_reg;
            `PDF_OFS_GENB:   rd_next = gen_actions_second_reg;
            `PDF_OFS_DBCTL:  rd_next = {31'h0000_0000,
                                        deadband_control_reg};
            `PDF_OFS_DBRISE: rd_next = {20'h0_0000,
                                        deadband_rise_delay_reg};
            `PDF_OFS_DBFALL: rd_next = {20'h0_0000,
                                        deadband_fall_delay_reg};
            default:         rresp_next = 2'b10;
        endcase
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= 2'b00;
            irq_o          <= 1'b0;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o  <= rd_next;
                s_axi_rresp_o  <= rresp_next;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
            irq_o <= |isc_word;
        end
    end

    // ****************************************************************
    // Dead-band and output stage
    // ****************************************************************
    wire [1:0] db_wave;

    pdf_deadband u_deadband (
        .clk_i             (clk_i),
        .reset_n_i         (reset_n_i),
        .enable_i          (deadband_control_reg),
        .rise_delay_i      (deadband_rise_delay_reg),
        .fall_delay_i      (deadband_fall_delay_reg),
        .raw_wave_first_i  (raw_wave_first_i),
        .raw_wave_second_i (raw_wave_second_i),
        .db_first_o        (db_wave[0]),
        .db_second_o       (db_wave[1])
    );

    reg [1:0] pin_reg;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_out
            wire gated = db_wave[ch] & output_pin_enable_reg[ch];
            wire safe  = gated &
                ~(output_fault_force_reg[ch] & fault_cond);
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i)
                    pin_reg[ch] <= 1'b0;
                else
                    pin_reg[ch] <= safe ^
                        output_polarity_invert_reg[ch];
            end
        end
    endgenerate

    assign out_channel_zero_o = pin_reg[0];
    assign out_channel_one_o  = pin_reg[1];
endmodule

// >>> sim/pdf_top_asserts.sv
// Register bus handshake checks for the PWM back end.
`timescale 1ns/1ps
module pdf_top_asserts (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic [31:0] s_axi_rdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wr_answer_a: assert property (
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o) else $error("write answer missing");
    rd_answer_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer missing");
    b_hold_a: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write answer dropped");
    r_hold_a: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o)) else $error("read answer changed");
    b_okay_a: assert property (
        s_axi_bvalid_o |-> s_axi_bresp_o == 2'b00) else $error("bad bresp");
    aw_block_a: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during answer");
    ar_block_a: assert property (
        s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken early");
    unmapped_err_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 12'h0f0 |=>
        s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule
bind pdf_top pdf_top_asserts u_chk (.*);

// >>> sim/pdf_bridge_model.sv
// Half-bridge stand-in that flags both switches on at once.
`timescale 1ns/1ps
module pdf_bridge_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic arm_i,
    input  wire logic high_side_i,
    input  wire logic low_side_i,
    output logic      shoot_o
);
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) shoot_o <= 1'b0;
        else if (arm_i && high_side_i && low_side_i) shoot_o <= 1'b1;
    end
endmodule

// >>> sim/pdf_top_tb.sv
// Self-checking bench for the PWM back end.
`timescale 1ns/1ps
module pdf_top_tb;
    logic clk_i = 0, reset_n_i = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic w1 = 0, w2 = 0, flt = 0, stl = 0, arm = 0, ta, tw;
    logic [11:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rdv;
    logic [5:0]  ev = 0;
    wire awr, wr_, bv, arr, rv, c0, c1, irq, sh;
    wire [31:0] rd;
    wire [1:0]  br, rr;
    int n_mismatch = 0, cmp_count = 0;
    always #12.5 clk_i = ~clk_i;
    pdf_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(aw),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
        .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rre), .raw_wave_first_i(w1), .raw_wave_second_i(w2),
        .counter_event_i(ev), .fault_pin_i(flt), .debug_stall_i(stl),
        .out_channel_zero_o(c0), .out_channel_one_o(c1), .irq_o(irq));
    pdf_bridge_model bridge (.clk_i(clk_i), .reset_n_i(reset_n_i), .arm_i(arm),
        .high_side_i(c0), .low_side_i(c1), .shoot_o(sh));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Ready and answers are sampled at the rising edge the slave acts on,
    // so every request stands until the edge that takes it.
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        aw <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        ta = 0;
        tw = 0;
        while (!(ta && tw)) begin
            @(posedge clk_i);
            if (awr && !ta) begin
                ta = 1;
                awv <= 0;
            end
            if (wr_ && !tw) begin
                tw = 1;
                wv <= 0;
            end
        end
        do @(posedge clk_i); while (!bv);
        bre <= 0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_i);
        ar <= a;
        arv <= 1;
        rre <= 1;
        do @(posedge clk_i); while (!arr);
        arv <= 0;
        do @(posedge clk_i); while (!rv);
        rre <= 0;
        rdv = rd;
        chk("rdata", rdv, e);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #2000000 n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1;
        rdc(12'h040, 0);
        rdc(12'h0f0, 0);
        wr(12'h008, 3); @(posedge clk_i) w1 <= 1;
        cyc(4); chk("pins", {c1, c0}, 2'b01);
        $display("pass-through test done");
        wr(12'h06c, 4); wr(12'h070, 3); @(posedge clk_i) w1 <= 0;
        w2 <= 1; wr(12'h068, 1); arm <= 1; cyc(12);
        @(posedge clk_i) w1 <= 1;
        cyc(3); chk("pins", {c1, c0}, 2'b00);
        cyc(8); chk("pins", {c1, c0}, 2'b01);
        @(posedge clk_i) w1 <= 0;
        cyc(3); chk("pins", {c1, c0}, 2'b00);
        cyc(8); chk("pins", {c1, c0}, 2'b10);
        arm <= 0; wr(12'h068, 0); chk("shoot", sh, 0);
        $display("dead-band test done");
        wr(12'h010, 3); wr(12'h00c, 2); wr(12'h014, 32'h0001_0000);
        @(posedge clk_i) w1 <= 1; flt <= 1;
        cyc(5); chk("pins", {c1, c0}, 2'b10);
        rdc(12'h020, 1); chk("irq", irq, 1);
        @(posedge clk_i) flt <= 0;
        cyc(5); chk("irq", irq, 1);
        wr(12'h01c, 32'h0001_0000); cyc(2); chk("irq", irq, 0);
        @(posedge clk_i) stl <= 1;
        cyc(5); chk("pins", {c1, c0}, 2'b10);
        rdc(12'h018, 0); chk("irq", irq, 0);
        @(posedge clk_i) stl <= 0;
        $display("fault test done");
        wr(12'h008, 0); wr(12'h00c, 3); cyc(4);
        chk("pins", {c1, c0}, 2'b11);
        // A write lands two edges after its request and a read samples one
        // edge after its request; the expected counts below rest on that.
        // A period of ten ticks is loaded as nine.
        wr(12'h050, 9);
        wr(12'h040, 1);
        rdc(12'h054, 8);
        wr(12'h050, 3);
        rdc(12'h054, 1);
        rdc(12'h054, 2);
        @(posedge clk_i) stl <= 1;
        cyc(4);
        rdc(12'h054, 0);
        @(posedge clk_i) stl <= 0;
        wr(12'h040, 0);
        rdc(12'h054, 3);
        wr(12'h004, 1);
        rdc(12'h054, 0);
        rdc(12'h004, 0);
        wr(12'h050, 5);
        wr(12'h040, 5);
        rdc(12'h054, 2);
        wr(12'h000, 1);
        rdc(12'h054, 5);
        rdc(12'h000, 0);
        $display("counter test done");
        wr(12'h044, 1); wr(12'h014, 1); @(posedge clk_i) ev <= 6'h01;
        @(posedge clk_i) ev <= 6'h00;
        cyc(3); chk("irq", irq, 1);
        wr(12'h04c, 1); cyc(2); chk("irq", irq, 0);
        $display("control test done");
        report_and_stop;
    end
endmodule
